/* File: hdl/freq_status_defs.vh */
`ifndef FREQ_STATUS_DEFS_VH
`define FREQ_STATUS_DEFS_VH

// ==========================================================
// Register geometry
`define FS_WIDTH 15
`define FS_MSB 14
`define FS_VALUE_WIDTH 16
`define FS_VALUE_MSB 15

// ==========================================================
// Command codes on the command port
`define FS_CODE_WIDTH 4
`define FS_CMD_NONE 4'h0
`define FS_CMD_COND_QUERY 4'h1
`define FS_CMD_ENAB_WRITE 4'h2
`define FS_CMD_ENAB_QUERY 4'h3
`define FS_CMD_EVENT_QUERY 4'h4
`define FS_CMD_FALL_WRITE 4'h5
`define FS_CMD_FALL_QUERY 4'h6
`define FS_CMD_RISE_WRITE 4'h7
`define FS_CMD_RISE_QUERY 4'h8
`define FS_CMD_STATUS_PRESET 4'h9

// ==========================================================
// Parameter kinds: plain number or a bound keyword
`define FS_ARG_NUMBER 2'h0
`define FS_ARG_MAX 2'h1
`define FS_ARG_MIN 2'h2

// ==========================================================
// Value limits of a written number
`define FS_LIMIT_MAX 16'h7fff
`define FS_LIMIT_MIN 16'h0000

// ==========================================================
// Status-preset and reset values
`define FS_PRESET_ENABLE 15'h7fff
`define FS_PRESET_RISE 15'h7fff
`define FS_PRESET_FALL 15'h0000
`define FS_RESET_EVENT 15'h0000
`define FS_RESET_REPLY 16'h0000
`define FS_RESET_COND 15'h0000

`endif

/* File: hdl/cond_sync.v */
`timescale 1ns/10ps
`include "freq_status_defs.vh"
// ==========================================================
// Two-stage synchroniser for the condition inputs
module cond_sync (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Asynchronous condition levels
    input wire [14:0] cond_async,
    // Synchronised condition levels
    output wire [14:0] cond_sync_out
);

reg [14:0] meta_reg;
reg [14:0] stable_reg;

// First stage feeds only the second stage
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        meta_reg <= `FS_RESET_COND;
        stable_reg <= `FS_RESET_COND;
    end else begin
        meta_reg <= cond_async;
        stable_reg <= meta_reg;
    end
end

assign cond_sync_out = stable_reg;

endmodule // cond_sync

/* File: hdl/edge_filter.v */
`timescale 1ns/10ps
`include "freq_status_defs.vh"
// ==========================================================
// Transition filter: turns condition edges into event sets
module edge_filter (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Synchronised condition and filter masks
    input wire [14:0] cond_now,
    input wire [14:0] rise_mask,
    input wire [14:0] fall_mask,
    // Previous condition and per-bit event sets
    output wire [14:0] cond_prev,
    output wire [14:0] event_set
);

reg [14:0] prev_reg;

// Remember last cycle's condition
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        prev_reg <= `FS_RESET_COND;
    end else begin
        prev_reg <= cond_now;
    end
end

assign cond_prev = prev_reg;
// Rising edge through rise mask, falling edge through fall mask
assign event_set = (cond_now & ~prev_reg & rise_mask) |
                   (~cond_now & prev_reg & fall_mask); // (R10)

endmodule // edge_filter

/* File: hdl/freq_status_set.v */
// Function
// (R1) A condition query answers the sum of weights 2**n of all set bits.
// (R2) The condition register is live and a read leaves it untouched.
// (R3) An enable write of summed weights 0..32767 or MAX/MIN loads the mask.
// (R4) An enable query answers the stored mask in the same encoding.
// (R5) An event query answers the latched events and then clears them.
// (R6) A falling filter write is stored and answered unchanged on query.
// (R7) A rising filter write is stored and answered unchanged on query.
// (R8) Enable and both filters keep their contents on instrument preset.
// (R9) Status preset sets enable to ones, rising to ones, falling to zeros.
// (R10) An event bit sets on a filtered rise or fall and holds until read.
`timescale 1ns/10ps
`include "freq_status_defs.vh"

// ==========================================================
// Frequency questionable-status register set
module freq_status_set (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Condition levels from the frequency monitors
    input wire [14:0] freq_cond_in,
    // Command port from the remote controller
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [1:0] cmd_arg_kind,
    input wire [15:0] cmd_value,
    output wire cmd_ready,
    // General instrument preset
    input wire instrument_preset,
    // Reply port
    output wire reply_valid,
    output wire [15:0] reply_data,
    output wire cmd_error,
    // Status outputs
    output wire [14:0] freq_condition_live,
    output wire event_summary
);

// ==========================================================
// Decode of the written argument

// Resolves a number or bound keyword to a 16-bit value
function [15:0] arg_value;
    input [1:0] kind;
    input [15:0] value;
    begin
        case (kind)
            `FS_ARG_MAX: arg_value = `FS_LIMIT_MAX;
            `FS_ARG_MIN: arg_value = `FS_LIMIT_MIN;
            default: arg_value = value;
        endcase
    end
endfunction

// True when the argument is a legal bound or in-range number
// Kind 3 is refused, as is a number above the upper limit
function arg_legal;
    input [1:0] kind;
    input [15:0] value;
    begin
        case (kind)
            `FS_ARG_MAX: arg_legal = 1'b1;
            `FS_ARG_MIN: arg_legal = 1'b1;
            `FS_ARG_NUMBER: arg_legal = (value <= `FS_LIMIT_MAX);
            default: arg_legal = 1'b0;
        endcase
    end
endfunction

// Widens a 15-bit register to the reply width
// Bit 15 of every reply stays zero: the registers hold 15 bits
function [15:0] to_reply;
    input [14:0] bits;
    begin
        to_reply = {1'b0, bits};
    end
endfunction

// True when a valid command carries the wanted code
function cmd_hit;
    input valid;
    input [3:0] code;
    input [3:0] want;
    begin
        cmd_hit = valid && (code == want);
    end
endfunction

// ==========================================================
// Registers and nets
reg [14:0] enable_reg;
reg [14:0] enable_next;
reg [14:0] rise_reg;
reg [14:0] rise_next;
reg [14:0] fall_reg;
reg [14:0] fall_next;
reg [14:0] event_reg;
reg [14:0] event_next;
reg [15:0] reply_data_reg;
reg [15:0] reply_data_next;
reg reply_valid_reg;
reg reply_valid_next;
reg cmd_error_reg;
reg cmd_error_next;
reg summary_reg;

wire [14:0] cond_live;
wire [14:0] event_set;
wire summary_next;
wire status_preset;
wire enable_write;
wire fall_write;
wire rise_write;
wire [15:0] write_value;
wire write_ok;
wire is_write;
wire event_clear;

// ==========================================================
// Condition path

// Monitor levels come from outside the clock domain
// Two flops keep a metastable level away from the edge filter
cond_sync u_cond_sync (
    .mclk(mclk),
    .resetn(resetn),
    .cond_async(freq_cond_in),
    .cond_sync_out(cond_live)
);

// Edge filtering into per-bit event sets
edge_filter u_edge_filter (
    .mclk(mclk),
    .resetn(resetn),
    .cond_now(cond_live),
    .rise_mask(rise_reg),
    .fall_mask(fall_reg),
    .cond_prev(),
    .event_set(event_set)
);

// ==========================================================
// Command decode

// Argument shared by the three write commands
assign write_value = arg_value(cmd_arg_kind, cmd_value); // (R3)
assign write_ok = arg_legal(cmd_arg_kind, cmd_value); // (R3)
assign is_write = (cmd_code == `FS_CMD_ENAB_WRITE) ||
                  (cmd_code == `FS_CMD_FALL_WRITE) ||
                  (cmd_code == `FS_CMD_RISE_WRITE);
assign event_clear = cmd_hit(cmd_valid, cmd_code, `FS_CMD_EVENT_QUERY);

// One strobe per register-changing command; a refused write changes
// nothing, since out-of-range numbers are neither clamped nor masked
assign status_preset = cmd_hit(cmd_valid, cmd_code, `FS_CMD_STATUS_PRESET);
assign enable_write = cmd_hit(cmd_valid, cmd_code, `FS_CMD_ENAB_WRITE) &&
                      write_ok; // (R3)
assign fall_write = cmd_hit(cmd_valid, cmd_code, `FS_CMD_FALL_WRITE) &&
                    write_ok; // (R6)
assign rise_write = cmd_hit(cmd_valid, cmd_code, `FS_CMD_RISE_WRITE) &&
                    write_ok; // (R7)

// The block takes one command in every cycle
// so back-to-back commands need no wait state
assign cmd_ready = 1'b1;

// ==========================================================
// Enable mask next value
always @* begin
    enable_next = enable_reg;
    if (status_preset) begin
        enable_next = `FS_PRESET_ENABLE; // (R9)
    end else if (enable_write) begin
        enable_next = write_value[14:0]; // (R3)
    end
    // Instrument preset leaves the mask alone (R8)
end

// ==========================================================
// Rising filter next value
always @* begin
    rise_next = rise_reg;
    if (status_preset) begin
        rise_next = `FS_PRESET_RISE; // (R9)
    end else if (rise_write) begin
        rise_next = write_value[14:0]; // (R7)
    end
    // Instrument preset leaves the filter alone (R8)
end

// ==========================================================
// Falling filter next value
always @* begin
    fall_next = fall_reg;
    if (status_preset) begin
        fall_next = `FS_PRESET_FALL; // (R9)
    end else if (fall_write) begin
        fall_next = write_value[14:0]; // (R6)
    end
    // Instrument preset leaves the filter alone (R8)
end

// ==========================================================
// Event latch: a new event in the clearing cycle survives
// The reply carries the events latched before the query; a read in
// the cycle of a new edge must not lose that edge
always @* begin
    event_next = event_reg;
    if (event_clear) begin
        event_next = `FS_RESET_EVENT; // (R5)
    end
    event_next = event_next | event_set; // (R10)
end

// ==========================================================
// Reply and error next values
// Reply data holds the last answer until the next query
always @* begin
    reply_data_next = reply_data_reg;
    reply_valid_next = 1'b0;
    cmd_error_next = 1'b0;
    if (cmd_valid) begin
        case (cmd_code)
            `FS_CMD_COND_QUERY: begin
                reply_data_next = to_reply(cond_live); // (R1) (R2)
                reply_valid_next = 1'b1;
            end
            `FS_CMD_ENAB_QUERY: begin
                reply_data_next = to_reply(enable_reg); // (R4)
                reply_valid_next = 1'b1;
            end
            `FS_CMD_EVENT_QUERY: begin
                reply_data_next = to_reply(event_reg); // (R5)
                reply_valid_next = 1'b1;
            end
            `FS_CMD_FALL_QUERY: begin
                reply_data_next = to_reply(fall_reg); // (R6)
                reply_valid_next = 1'b1;
            end
            `FS_CMD_RISE_QUERY: begin
                reply_data_next = to_reply(rise_reg); // (R7)
                reply_valid_next = 1'b1;
            end
            `FS_CMD_ENAB_WRITE,
            `FS_CMD_FALL_WRITE,
            `FS_CMD_RISE_WRITE: begin
                cmd_error_next = is_write && !write_ok;
            end
            `FS_CMD_STATUS_PRESET: begin
                cmd_error_next = 1'b0;
            end
            // Unknown codes change nothing and only flag the error
            default: begin
                cmd_error_next = 1'b1;
            end
        endcase
    end
end

// ==========================================================
// Configuration registers, started in their status-preset state
// A fresh part reads like one just after a status preset
// The instrument preset reaches none of these registers (R8)
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        enable_reg <= `FS_PRESET_ENABLE;
        rise_reg <= `FS_PRESET_RISE;
        fall_reg <= `FS_PRESET_FALL;
    end else begin
        enable_reg <= enable_next;
        rise_reg <= rise_next;
        fall_reg <= fall_next;
    end
end

// ==========================================================
// Event and reply registers
always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
        event_reg <= `FS_RESET_EVENT;
        reply_data_reg <= `FS_RESET_REPLY;
        reply_valid_reg <= 1'b0;
        cmd_error_reg <= 1'b0;
        summary_reg <= 1'b0;
    end else begin
        event_reg <= event_next;
        reply_data_reg <= reply_data_next;
        reply_valid_reg <= reply_valid_next;
        cmd_error_reg <= cmd_error_next;
        summary_reg <= summary_next;
    end
end

// ==========================================================
// Outputs
assign reply_valid = reply_valid_reg;
assign reply_data = reply_data_reg;
assign cmd_error = cmd_error_reg;
// Condition output is the synchronised level that queries report
assign freq_condition_live = cond_live; // (R2)
// Any enabled latched event, taken from the next values so that the
// registered summary moves in the same cycle as the registers
assign summary_next = |(event_next & enable_next);
assign event_summary = summary_reg;

endmodule // freq_status_set

/* File: sim/freq_status_checker.sv */
`timescale 1ns/10ps
// ==========================================
// Port checker for the status register set
module freq_status_checker (
    // Clock and reset
    input wire mclk,
    input wire resetn,
    // Inputs
    input wire [14:0] freq_cond_in,
    input wire cmd_valid,
    input wire [3:0] cmd_code,
    input wire [1:0] cmd_arg_kind,
    input wire [15:0] cmd_value,
    // Outputs
    input wire reply_valid,
    input wire [15:0] reply_data,
    input wire cmd_error,
    input wire [14:0] freq_condition_live
);
    // Query and refused-write decode
    wire is_q = cmd_valid && (cmd_code inside {4'h1, 4'h3, 4'h4, 4'h6, 4'h8});
    wire is_w = cmd_valid && (cmd_code inside {4'h2, 4'h5, 4'h7});
    wire bad_k = cmd_arg_kind == 2'h3;
    wire bad_v = cmd_arg_kind == 2'h0 && cmd_value > 16'h7fff;
    wire bad_wr = is_w && (bad_k || bad_v);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    reply_pulse_a: assert property (is_q |=> reply_valid)
        else $error("no reply after query");
    reply_cause_a: assert property (reply_valid |-> $past(is_q))
        else $error("reply without query");
    cond_reply_a: assert property (is_q && cmd_code == 4'h1
        |=> reply_data == {1'b0, $past(freq_condition_live)})
        else $error("condition reply wrong");
    cond_path_a: assert property ($past(resetn, 2) && $past(resetn)
        |-> freq_condition_live == $past(freq_cond_in, 2))
        else $error("condition path wrong");
    refuse_write_a: assert property (bad_wr |=> cmd_error)
        else $error("bad write not refused");
    err_cause_a: assert property (cmd_error |-> $past(cmd_valid))
        else $error("error without command");
    msb_zero_a: assert property (reply_valid |-> !reply_data[15])
        else $error("reply bit 15 set");
    reply_keep_a: assert property (!reply_valid |-> $stable(reply_data))
        else $error("reply data moved");
    // Main scenarios reached
    cover property (is_q && cmd_code == 4'h4 ##1 reply_data != 16'h0000);
    cover property (bad_wr);
    cover property (is_w ##1 is_q);
endmodule // freq_status_checker
bind freq_status_set freq_status_checker i_freq_status_checker (
    .mclk(mclk), .resetn(resetn), .freq_cond_in(freq_cond_in),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg_kind(cmd_arg_kind), .cmd_value(cmd_value),
    .reply_valid(reply_valid), .reply_data(reply_data),
    .cmd_error(cmd_error), .freq_condition_live(freq_condition_live));

/* File: sim/ctrl_model.sv */
`timescale 1ns/10ps
// ==========================================
// Remote controller issuing status commands
module ctrl_model (
    // Clock
    input wire mclk,
    // Command side
    output logic cmd_valid,
    output logic [3:0] cmd_code,
    output logic [1:0] cmd_arg_kind,
    output logic [15:0] cmd_value,
    // Reply side
    input wire reply_valid,
    input wire [15:0] reply_data,
    input wire cmd_error
);
    // Idle until the first command
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 4'h0;
        cmd_arg_kind = 2'h0;
        cmd_value = 16'h0000;
    end
    // One command; reply taken in the following cycle
    task send(input [3:0] c, input [1:0] k, input [15:0] v,
              output [17:0] r);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_arg_kind = k;
        cmd_value = v;
        @(negedge mclk);
        r = {reply_valid, cmd_error, reply_data};
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_arg_kind = ~k;
        cmd_value = ~v;
    endtask
endmodule // ctrl_model

/* File: sim/tb.sv */
`timescale 1ns/10ps
// ==========================================
// Testbench for the status register set
module tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [14:0] cond_in = 15'h0000;
    logic preset = 1'b0;
    logic [17:0] r;
    wire cmd_valid, cmd_ready, reply_valid, cmd_error, summ;
    wire [3:0] cmd_code;
    wire [1:0] cmd_arg_kind;
    wire [15:0] cmd_value, reply_data;
    wire [14:0] live;
    int mismatches = 0;
    int check_count = 0;
    // Clock
    always #2 mclk = ~mclk;
    freq_status_set i_freq_status_set (.mclk(mclk), .resetn(resetn),
        .freq_cond_in(cond_in), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg_kind(cmd_arg_kind),
        .cmd_value(cmd_value), .cmd_ready(cmd_ready),
        .instrument_preset(preset), .reply_valid(reply_valid),
        .reply_data(reply_data), .cmd_error(cmd_error),
        .freq_condition_live(live), .event_summary(summ));
    ctrl_model i_ctrl_model (.mclk(mclk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg_kind(cmd_arg_kind),
        .cmd_value(cmd_value), .reply_valid(reply_valid),
        .reply_data(reply_data), .cmd_error(cmd_error));
    // Compare and count
    task chk(input string n, input [17:0] e, input [17:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task qry(input [3:0] c, input [14:0] e);
        i_ctrl_model.send(c, 2'h0, 16'h0000, r);
        chk("reply", {3'b100, e}, r);
    endtask
    task wr(input [3:0] c, input [1:0] k, input [15:0] v, input bit er);
        i_ctrl_model.send(c, k, v, r);
        chk("write", {1'b0, er, 16'h0000}, {r[17:16], 16'h0000});
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Reset values
    task t_reset;
        qry(4'h3, 15'h7fff);
        qry(4'h8, 15'h7fff);
        qry(4'h6, 15'h0000);
        qry(4'h4, 15'h0000);
        chk("ready", 18'h00001, {17'h00000, cmd_ready});
        $display("t_reset done");
    endtask
    // Writes, bounds and refusals on all three registers
    task t_rw;
        logic [3:0] w [3] = '{4'h2, 4'h5, 4'h7};
        for (int i = 0; i < 3; i++) begin
            wr(w[i], 2'h0, 16'h7fff, 0);
            qry(w[i] + 4'h1, 15'h7fff);
            wr(w[i], 2'h2, 16'h1111, 0);
            qry(w[i] + 4'h1, 15'h0000);
            wr(w[i], 2'h1, 16'h0000, 0);
            qry(w[i] + 4'h1, 15'h7fff);
            wr(w[i], 2'h0, 16'h0005, 0);
            wr(w[i], 2'h0, 16'h8000, 1);
            wr(w[i], 2'h3, 16'h0001, 1);
            qry(w[i] + 4'h1, 15'h0005);
        end
        wr(4'ha, 2'h0, 16'h0000, 1);
        $display("t_rw done");
    endtask
    // Instrument preset keeps, status preset restores
    task t_preset;
        wr(4'h2, 2'h0, 16'h0000, 0);
        wr(4'h5, 2'h0, 16'h7fff, 0);
        wr(4'h7, 2'h0, 16'h0000, 0);
        @(negedge mclk) preset = 1'b1;
        @(negedge mclk) preset = 1'b0;
        qry(4'h3, 15'h0000);
        qry(4'h6, 15'h7fff);
        qry(4'h8, 15'h0000);
        wr(4'h9, 2'h0, 16'h0000, 0);
        qry(4'h3, 15'h7fff);
        qry(4'h6, 15'h0000);
        qry(4'h8, 15'h7fff);
        $display("t_preset done");
    endtask
    // Condition edges latch events that clear on read
    task t_events;
        wr(4'h5, 2'h0, 16'h00ff, 0);
        @(negedge mclk) cond_in = 15'h1234;
        repeat (4) @(negedge mclk);
        qry(4'h1, 15'h1234);
        qry(4'h1, 15'h1234);
        chk("summary", 18'h00001, {17'h00000, summ});
        qry(4'h4, 15'h1234);
        qry(4'h4, 15'h0000);
        chk("summary", 18'h00000, {17'h00000, summ});
        wr(4'h7, 2'h0, 16'h0000, 0);
        @(negedge mclk) cond_in = 15'h0000;
        repeat (4) @(negedge mclk);
        qry(4'h4, 15'h0034);
        $display("t_events done");
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge mclk);
        resetn = 1'b1;
        t_reset;
        t_rw;
        t_preset;
        t_events;
        close_out;
    end
    // Watchdog
    initial begin
        #20000;
        mismatches++;
        close_out;
    end
endmodule // tb
